// File: spi_ctl_pkg.sv
package spi_ctl_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_FIRST  = 8'h00;
  localparam logic [7:0] OFS_SECOND = 8'h04;
  localparam logic [7:0] OFS_BAUD   = 8'h0C;
  localparam logic [7:0] OFS_IRQ    = 8'h14;
  localparam logic [7:0] OFS_SYNC   = 8'h1C;
  // Field positions in first_control_reg
  localparam int SOFT_RESET_BIT_POS  = 0;
  localparam int ENABLE_POS = 1;
  localparam int MODE_LSB   = 2;
  localparam int FORM_LSB   = 24;
  // Field positions in second_control_reg
  localparam int CHAR_WIDTH_LSB = 0;
  localparam int PLOAD_POS  = 6;
  localparam int SEL_LOW_WAKE_ENABLE_POS   = 9;
  localparam int MASTER_SEL_HW_CTRL_POS  = 13;
  localparam int ADDR_MATCH_MODE_LSB  = 14;
  localparam int RECEIVER_ON_POS   = 17;
  // Interrupt enable word: clear byte low, set byte at this lane
  localparam int IRQ_SET_LSB          = 16;
  localparam logic [7:0] IRQ_USED     = 8'h8F;
  localparam logic [7:0] IRQ_RST      = 8'h00;
  localparam logic [7:0] BAUD_RST     = 8'h00;
  localparam logic [31:0] WORD_RST    = 32'h0000_0000;
  // Encodings
  localparam logic [2:0] MODE_SLAVE   = 3'h2;
  localparam logic [2:0] MODE_MASTER  = 3'h3;
  localparam logic [3:0] FORM_ADDR    = 4'h2;
  localparam logic [1:0] ADDR_MATCH_MODE_MASK   = 2'h0;
  localparam logic [1:0] ADDR_MATCH_MODE_TWO    = 2'h1;
  localparam logic [1:0] ADDR_MATCH_MODE_RANGE  = 2'h2;
  localparam logic [2:0] CHAR_WIDTH_NINE  = 3'h1;
  // Synchronisation channels and their latency
  localparam int SYNC_SOFT_RESET_BIT  = 0;
  localparam int SYNC_ENABLE = 1;
  localparam int SYNC_SECOND = 2;
  localparam int SYNC_NUM    = 3;
  localparam int CLK_PERIOD_NS = 40;
  localparam int SYNC_TIME_NS  = 120;
  localparam int SYNC_CYCLES   = (SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// File: sync_busy_track.sv
`timescale 1ns/10ps
`default_nettype none
module sync_busy_track #(
  parameter int N      = 3,
  parameter int CNT_W  = 4,
  parameter int CYCLES = 3
) (
  // Clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         nrst_i,
  // Per-channel control
  input  wire logic [N-1:0] start_i,
  input  wire logic [N-1:0] clear_i,
  // Per-channel state
  output logic [N-1:0]      busy_o,
  output logic [N-1:0]      done_o
);
  typedef struct packed {
    logic [N-1:0]            busy;
    logic [N-1:0][CNT_W-1:0] cnt;
  } trk_t;

  trk_t st_ff;
  trk_t nxt_st;

  // A restart reloads the count, so the last write decides completion
  always_comb begin
    nxt_st = st_ff;
    for (int i = 0; i < N; i++) begin
      if (start_i[i]) begin
        nxt_st.busy[i] = 1'b1;
        nxt_st.cnt[i]  = CNT_W'(CYCLES - 1);
      end else if (clear_i[i]) begin
        nxt_st.busy[i] = 1'b0;
      end else if (st_ff.busy[i]) begin
        if (st_ff.cnt[i] == '0) begin
          nxt_st.busy[i] = 1'b0;
        end else begin
          nxt_st.cnt[i] = st_ff.cnt[i] - CNT_W'(1);
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign busy_o = st_ff.busy;

  // Completion shows in the last busy cycle, so results land on the edge that drops busy
  always_comb begin
    done_o = '0;
    for (int i = 0; i < N; i++) begin
      done_o[i] = st_ff.busy[i] && st_ff.cnt[i] == '0 && !start_i[i] && !clear_i[i];
    end
  end
endmodule
`default_nettype wire

// File: baud_tick_gen.sv
`timescale 1ns/10ps
`default_nettype none
module baud_tick_gen #(
  parameter int DIV_W = 8
) (
  // Clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             nrst_i,
  // Control
  input  wire logic             run_i,
  input  wire logic [DIV_W-1:0] div_i,
  // Half-period enable of the serial clock
  output logic                  tick_o
);
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             tick;
  } div_t;

  div_t st_ff;
  div_t nxt_st;

  // Tick every div+1 cycles; held at zero while stopped
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.tick = 1'b0;
    if (!run_i) begin
      nxt_st.cnt = '0;
    end else if (st_ff.cnt >= div_i) begin
      nxt_st.cnt  = '0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + DIV_W'(1);
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick_o = st_ff.tick;
endmodule
`default_nettype wire

// File: spi_control_register_logic.sv
`timescale 1ns/10ps
`default_nettype none
module spi_control_register_logic (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  // Peripheral bus
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Serial side status
  input  wire logic        sel_n_i,
  input  wire logic        xfer_active_i,
  input  wire logic        data_write_i,
  input  wire logic        rx_overflow_i,
  input  wire logic        addr_valid_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [7:0]  addr_reg_i,
  input  wire logic [7:0]  addr_second_value_i,
  // Control outputs
  output logic             enabled_o,
  output logic             master_o,
  output logic             receiver_on_o,
  output logic             rx_flush_o,
  output logic             rx_overrun_flag_o,
  output logic             nine_bit_o,
  output logic             sclk_tick_o,
  output logic             sel_n_o,
  output logic             sel_oe_o,
  output logic             wake_o,
  output logic             preload_o,
  output logic             addr_match_o,
  output logic [7:0]       irq_enable_o
);
  typedef struct packed {
    logic        soft_reset_bit_bit;
    logic        en_bit;
    logic        enabled;
    logic [2:0]  mode;
    logic [3:0]  form;
    logic        receiver_on_req;
    logic        rx_run;
    logic [1:0]  addr_match_mode;
    logic        master_sel_hw_ctrl;
    logic        sel_low_wake_enable;
    logic        pload;
    logic [2:0]  char_width;
    logic [7:0]  baud;
    logic [7:0]  irq_en;
    logic        ovf;
    logic [31:0] prdata;
    logic        sel_prev;
    logic        sel_out;
    logic        wake;
    logic        preload;
    logic        flush;
    logic        addr_match;
  } ctl_t;

  ctl_t st_ff;
  ctl_t nxt_st;

  logic [spi_ctl_pkg::SYNC_NUM-1:0] sync_start;
  logic [spi_ctl_pkg::SYNC_NUM-1:0] sync_clear;
  logic [spi_ctl_pkg::SYNC_NUM-1:0] sync_busy;
  logic [spi_ctl_pkg::SYNC_NUM-1:0] sync_done;
  logic [31:0] rd_val;
  logic        wr;
  logic        wr_ok;
  logic        soft_reset_bit_start;
  logic        protect;
  logic        is_slave;
  logic        is_master;
  logic        receiver_on_view;

  // Address comparison for addressed slave frames
  function automatic logic addr_hit(input logic [1:0] m, input logic [7:0] a, input logic [7:0] ra,
                                    input logic [7:0] rb);
    case (m)
      spi_ctl_pkg::ADDR_MATCH_MODE_MASK:  addr_hit = ((a ^ ra) & ~rb) == 8'h00;
      spi_ctl_pkg::ADDR_MATCH_MODE_TWO:   addr_hit = (a == ra) || (a == rb);
      spi_ctl_pkg::ADDR_MATCH_MODE_RANGE: addr_hit = (a >= rb) && (a <= ra);
      default:                  addr_hit = 1'b0;
    endcase
  endfunction

  // Bus qualifiers; no wait states so the access phase always completes
  assign wr          = psel_i && penable_i && pwrite_i;
  assign wr_ok       = wr && !sync_busy[spi_ctl_pkg::SYNC_SOFT_RESET_BIT];
  assign soft_reset_bit_start = wr_ok && paddr_i == spi_ctl_pkg::OFS_FIRST && pwdata_i[spi_ctl_pkg::SOFT_RESET_BIT_POS];
  assign protect     = st_ff.en_bit || st_ff.enabled;
  assign is_slave    = st_ff.mode == spi_ctl_pkg::MODE_SLAVE;
  assign is_master   = st_ff.mode == spi_ctl_pkg::MODE_MASTER;
  assign receiver_on_view   = st_ff.enabled ? st_ff.rx_run : st_ff.receiver_on_req;

  // Synchronisation starts; soft reset cancels the other channels
  always_comb begin
    sync_start = '0;
    sync_clear = '0;
    sync_start[spi_ctl_pkg::SYNC_SOFT_RESET_BIT]  = soft_reset_bit_start;
    sync_start[spi_ctl_pkg::SYNC_ENABLE] = wr_ok && !soft_reset_bit_start && paddr_i == spi_ctl_pkg::OFS_FIRST;
    sync_start[spi_ctl_pkg::SYNC_SECOND] = (wr_ok && paddr_i == spi_ctl_pkg::OFS_SECOND && st_ff.enabled
                                            && pwdata_i[spi_ctl_pkg::RECEIVER_ON_POS])
                                           || (sync_done[spi_ctl_pkg::SYNC_ENABLE] && st_ff.en_bit
                                            && st_ff.receiver_on_req);
    sync_clear[spi_ctl_pkg::SYNC_ENABLE] = soft_reset_bit_start;
    sync_clear[spi_ctl_pkg::SYNC_SECOND] = soft_reset_bit_start;
  end

  sync_busy_track #(
    .N      (spi_ctl_pkg::SYNC_NUM),
    .CNT_W  (4),
    .CYCLES (spi_ctl_pkg::SYNC_CYCLES)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .start_i   (sync_start),
    .clear_i   (sync_clear),
    .busy_o    (sync_busy),
    .done_o    (sync_done)
  );

  // Serial clock only runs for an enabled master
  baud_tick_gen #(
    .DIV_W (8)
  ) u_baud (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .run_i     (st_ff.enabled && is_master),
    .div_i     (st_ff.baud),
    .tick_o    (sclk_tick_o)
  );

  // Read mux; unused positions stay zero
  always_comb begin
    rd_val = spi_ctl_pkg::WORD_RST;
    case (paddr_i)
      spi_ctl_pkg::OFS_FIRST: begin
        rd_val[spi_ctl_pkg::SOFT_RESET_BIT_POS]     = st_ff.soft_reset_bit_bit;
        rd_val[spi_ctl_pkg::ENABLE_POS]    = st_ff.en_bit;
        rd_val[spi_ctl_pkg::MODE_LSB +: 3] = st_ff.mode;
        rd_val[spi_ctl_pkg::FORM_LSB +: 4] = st_ff.form;
      end
      spi_ctl_pkg::OFS_SECOND: begin
        rd_val[spi_ctl_pkg::CHAR_WIDTH_LSB +: 3] = st_ff.char_width;
        rd_val[spi_ctl_pkg::PLOAD_POS]       = st_ff.pload;
        rd_val[spi_ctl_pkg::SEL_LOW_WAKE_ENABLE_POS]        = st_ff.sel_low_wake_enable;
        rd_val[spi_ctl_pkg::MASTER_SEL_HW_CTRL_POS]       = st_ff.master_sel_hw_ctrl;
        rd_val[spi_ctl_pkg::ADDR_MATCH_MODE_LSB +: 2]  = st_ff.addr_match_mode;
        rd_val[spi_ctl_pkg::RECEIVER_ON_POS]        = receiver_on_view;
      end
      spi_ctl_pkg::OFS_BAUD: rd_val[7:0] = st_ff.baud;
      spi_ctl_pkg::OFS_IRQ: begin
        rd_val[7:0]                         = st_ff.irq_en;
        rd_val[spi_ctl_pkg::IRQ_SET_LSB +: 8] = st_ff.irq_en;
      end
      spi_ctl_pkg::OFS_SYNC: rd_val[2:0] = sync_busy;
      default: rd_val = spi_ctl_pkg::WORD_RST;
    endcase
    // Busy flags stay visible so software can poll the reset itself
    if (sync_busy[spi_ctl_pkg::SYNC_SOFT_RESET_BIT] && paddr_i != spi_ctl_pkg::OFS_SYNC) begin
      rd_val = spi_ctl_pkg::WORD_RST;
    end
  end

  // Next state of all control registers
  always_comb begin
    nxt_st          = st_ff;
    nxt_st.flush    = 1'b0;
    nxt_st.wake     = 1'b0;
    nxt_st.preload  = 1'b0;
    nxt_st.sel_prev = sel_n_i;
    nxt_st.sel_out  = !xfer_active_i;
    if (psel_i && !penable_i) begin
      nxt_st.prdata = rd_val;
    end
    if (sync_done[spi_ctl_pkg::SYNC_SOFT_RESET_BIT]) begin
      nxt_st.soft_reset_bit_bit = 1'b0;
    end
    if (sync_done[spi_ctl_pkg::SYNC_ENABLE]) begin
      nxt_st.enabled = st_ff.en_bit;
      if (!st_ff.en_bit) begin
        nxt_st.rx_run = 1'b0;
      end
    end
    if (sync_done[spi_ctl_pkg::SYNC_SECOND]) begin
      nxt_st.rx_run = st_ff.receiver_on_req && st_ff.enabled;
    end
    if (rx_overflow_i && st_ff.rx_run) begin
      nxt_st.ovf = 1'b1;
    end
    // Falling select edge wakes an enabled slave
    if (st_ff.enabled && is_slave && st_ff.sel_low_wake_enable && st_ff.sel_prev && !sel_n_i) begin
      nxt_st.wake = 1'b1;
    end
    if (st_ff.enabled && is_slave && st_ff.pload && data_write_i && sel_n_i && !xfer_active_i) begin
      nxt_st.preload = 1'b1;
    end
    // Master ignores address mode and passes every frame
    if (addr_valid_i) begin
      if (is_slave && st_ff.form == spi_ctl_pkg::FORM_ADDR) begin
        nxt_st.addr_match = addr_hit(st_ff.addr_match_mode, addr_i, addr_reg_i, addr_second_value_i);
      end else begin
        nxt_st.addr_match = 1'b1;
      end
    end
    if (wr_ok && paddr_i == spi_ctl_pkg::OFS_FIRST) begin
      if (soft_reset_bit_start) begin
        nxt_st           = '0;
        nxt_st.soft_reset_bit_bit = 1'b1;
        nxt_st.sel_prev  = sel_n_i;
        nxt_st.sel_out   = 1'b1;
      end else begin
        nxt_st.en_bit = pwdata_i[spi_ctl_pkg::ENABLE_POS];
        if (!protect) begin
          nxt_st.mode = pwdata_i[spi_ctl_pkg::MODE_LSB +: 3];
          nxt_st.form = pwdata_i[spi_ctl_pkg::FORM_LSB +: 4];
        end
      end
    end
    if (wr_ok && paddr_i == spi_ctl_pkg::OFS_SECOND) begin
      if (!protect) begin
        nxt_st.char_width = pwdata_i[spi_ctl_pkg::CHAR_WIDTH_LSB +: 3];
        nxt_st.pload  = pwdata_i[spi_ctl_pkg::PLOAD_POS];
        nxt_st.sel_low_wake_enable   = pwdata_i[spi_ctl_pkg::SEL_LOW_WAKE_ENABLE_POS];
        nxt_st.master_sel_hw_ctrl  = pwdata_i[spi_ctl_pkg::MASTER_SEL_HW_CTRL_POS];
        nxt_st.addr_match_mode  = pwdata_i[spi_ctl_pkg::ADDR_MATCH_MODE_LSB +: 2];
      end
      // Flush wins over a same-cycle overflow: that character is discarded
      if (!pwdata_i[spi_ctl_pkg::RECEIVER_ON_POS]) begin
        nxt_st.receiver_on_req = 1'b0;
        nxt_st.rx_run   = 1'b0;
        nxt_st.flush    = 1'b1;
        nxt_st.ovf      = 1'b0;
      end else begin
        nxt_st.receiver_on_req = 1'b1;
      end
    end
    if (wr_ok && paddr_i == spi_ctl_pkg::OFS_BAUD && !protect) begin
      nxt_st.baud = pwdata_i[7:0];
    end
    // Set lane first, clear lane last; unused bits never stick
    if (wr_ok && paddr_i == spi_ctl_pkg::OFS_IRQ) begin
      nxt_st.irq_en = (st_ff.irq_en | (pwdata_i[spi_ctl_pkg::IRQ_SET_LSB +: 8] & spi_ctl_pkg::IRQ_USED))
                      & ~(pwdata_i[7:0] & spi_ctl_pkg::IRQ_USED);
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_ff          <= '0;
      st_ff.sel_prev <= 1'b1;
      st_ff.sel_out  <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs
  assign prdata_o          = st_ff.prdata;
  assign pready_o          = 1'b1;
  assign pslverr_o         = wr && sync_busy[spi_ctl_pkg::SYNC_SOFT_RESET_BIT];
  assign enabled_o         = st_ff.enabled;
  assign master_o          = is_master;
  assign receiver_on_o     = st_ff.rx_run;
  assign rx_flush_o        = st_ff.flush;
  assign rx_overrun_flag_o = st_ff.ovf;
  assign nine_bit_o        = st_ff.char_width == spi_ctl_pkg::CHAR_WIDTH_NINE;
  assign sel_n_o           = st_ff.sel_out;
  assign sel_oe_o          = st_ff.enabled && is_master && st_ff.master_sel_hw_ctrl;
  assign wake_o            = st_ff.wake;
  assign preload_o         = st_ff.preload;
  assign addr_match_o      = st_ff.addr_match;
  assign irq_enable_o      = st_ff.irq_en;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  en_readback_a: assert property (sync_start[1] |=> st_ff.en_bit == $past(pwdata_i[1]) && sync_busy[1])
    else $error("enable bit not read back with busy set");
  soft_reset_bit_prio_a: assert property (soft_reset_bit_start |=> st_ff.soft_reset_bit_bit && !st_ff.en_bit && st_ff.mode == 3'h0)
    else $error("soft reset did not override write");
  soft_reset_bit_err_a: assert property (wr && sync_busy[0] |-> pslverr_o)
    else $error("write during soft reset without error");
  soft_reset_bit_read_a: assert property (psel_i && !penable_i && sync_busy[0] && paddr_i != 8'h1C |=> prdata_o == 32'h0)
    else $error("nonzero read during soft reset");
  soft_reset_bit_pair_a: assert property (st_ff.soft_reset_bit_bit == sync_busy[0])
    else $error("soft reset bit and busy flag disagree");
  rx_flush_a: assert property (wr_ok && paddr_i == 8'h04 && !pwdata_i[17] |=> rx_flush_o && !receiver_on_o && !rx_overrun_flag_o)
    else $error("receiver disable did not flush");
  rx_early_a: assert property (wr_ok && paddr_i == 8'h04 && pwdata_i[17] && !st_ff.enabled |=> st_ff.receiver_on_req)
    else $error("receiver enable not set at once");
  rx_wait_a: assert property ($rose(sync_busy[2]) |-> !receiver_on_o ##[1:4] !sync_busy[2])
    else $error("receiver sync did not finish in time");
  irq_clear_a: assert property (wr_ok && paddr_i == 8'h14 |=> (irq_enable_o & $past(pwdata_i[7:0])) == 8'h00)
    else $error("interrupt enable not cleared");
  baud_lock_a: assert property (wr_ok && paddr_i == 8'h0C && protect |=> $stable(st_ff.baud))
    else $error("protected baud written while enabled");

  enable_seen_c: cover property (sync_done[1] && st_ff.en_bit);
  soft_reset_bit_seen_c: cover property (sync_done[0]);
  rx_start_c: cover property ($rose(receiver_on_o));
  wake_seen_c: cover property (wake_o);
endmodule
`default_nettype wire

// File: spi_peer_model.sv
`timescale 1ns/10ps
`default_nettype none
module spi_peer_model (
  // Clock
  input  wire logic       ref_clk_i,
  // Serial side status seen by the block
  output logic            sel_n_o,
  output logic            xfer_o,
  output logic            ovf_o,
  output logic            addr_valid_o,
  output logic [7:0]      addr_o
);
  // Select idles high as if pulled up; no transfer at start
  initial begin
    sel_n_o      = 1'b1;
    xfer_o       = 1'b0;
    ovf_o        = 1'b0;
    addr_valid_o = 1'b0;
    addr_o       = 8'h00;
  end

  // First received byte; afterwards the bus shows the inverse, not a stale copy
  task automatic send_addr(input logic [7:0] a);
    @(negedge ref_clk_i);
    addr_o       = a;
    addr_valid_o = 1'b1;
    @(negedge ref_clk_i);
    addr_valid_o = 1'b0;
    addr_o       = ~a;
  endtask

  // One overflow event from the receive path
  task automatic pulse_ovf();
    @(negedge ref_clk_i);
    ovf_o = 1'b1;
    @(negedge ref_clk_i);
    ovf_o = 1'b0;
  endtask

  // Select and shifter levels change only off the sampling edge
  task automatic set_sel(input logic v);
    @(negedge ref_clk_i);
    sel_n_o = v;
  endtask

  task automatic set_xfer(input logic v);
    @(negedge ref_clk_i);
    xfer_o = v;
  endtask
endmodule
`default_nettype wire

// File: spi_control_register_logic_tb.sv
`timescale 1ns/10ps
`default_nettype none
module spi_control_register_logic_tb;
  logic        ref_clk_i, nrst_i, psel_i, penable_i, pwrite_i, data_write_i;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, rdata;
  logic        pready_o, pslverr_o, slverr, sel_n, xfer, ovf, avalid;
  logic [7:0]  addr, irq_enable_o, addr_ref, addr_alt;
  logic        enabled_o, master_o, receiver_on_o, rx_flush_o, rx_overrun_flag_o, nine_bit_o;
  logic        sclk_tick_o, sel_n_o, sel_oe_o, wake_o, preload_o, addr_match_o;
  int          error_cnt, n_checks, cyc, last_tick, tick_per, n_wake, n_pre, n_flush, w0;
  // Second-control image: width 9, preload, wake, hw select, receiver
  localparam logic [31:0] C2 = 32'h0002_2241;
  localparam logic [7:0] AD [4][2] = '{'{8'h60, 8'h41}, '{8'h20, 8'h30}, '{8'h30, 8'h41}, '{8'h40, 8'h20}};
  localparam logic [31:0] EX [4][2] = '{'{32'h1, 32'h0}, '{32'h1, 32'h0}, '{32'h1, 32'h0}, '{32'h0, 32'h0}};

  spi_control_register_logic uut (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .sel_n_i(sel_n), .xfer_active_i(xfer),
    .data_write_i(data_write_i), .rx_overflow_i(ovf), .addr_valid_i(avalid), .addr_i(addr),
    .addr_reg_i(addr_ref), .addr_second_value_i(addr_alt), .enabled_o(enabled_o), .master_o(master_o),
    .receiver_on_o(receiver_on_o), .rx_flush_o(rx_flush_o), .rx_overrun_flag_o(rx_overrun_flag_o),
    .nine_bit_o(nine_bit_o), .sclk_tick_o(sclk_tick_o), .sel_n_o(sel_n_o), .sel_oe_o(sel_oe_o),
    .wake_o(wake_o), .preload_o(preload_o), .addr_match_o(addr_match_o), .irq_enable_o(irq_enable_o));

  spi_peer_model u_peer (.ref_clk_i(ref_clk_i), .sel_n_o(sel_n), .xfer_o(xfer), .ovf_o(ovf),
    .addr_valid_o(avalid), .addr_o(addr));

  // 25 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  // Pulse counters and tick spacing, so one-cycle pulses are never missed
  always @(posedge ref_clk_i) begin
    cyc = cyc + 1;
    if (wake_o === 1'b1) n_wake = n_wake + 1;
    if (preload_o === 1'b1) n_pre = n_pre + 1;
    if (rx_flush_o === 1'b1) n_flush = n_flush + 1;
    if (sclk_tick_o === 1'b1) begin
      tick_per  = cyc - last_tick;
      last_tick = cyc;
    end
  end

  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Setup then access; request held until the sampling edge, back to back allowed
  task automatic xfer_bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(negedge ref_clk_i);
    psel_i = 1'b1; penable_i = 1'b0; pwrite_i = w; paddr_i = a; pwdata_i = d;
    @(negedge ref_clk_i);
    penable_i = 1'b1;
    @(posedge ref_clk_i);
    rdata  = prdata_o;
    slverr = pslverr_o;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer_bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    xfer_bus(1'b0, a, 32'h0000_0000);
  endtask

  task automatic idle(input int n);
    @(negedge ref_clk_i);
    psel_i = 1'b0; penable_i = 1'b0;
    repeat (n) @(posedge ref_clk_i);
  endtask

  // Poll busy flags with a bound; a stuck flag shows up as a later mismatch
  task automatic wait_sync();
    for (int i = 0; i < 20; i++) begin
      rd(spi_ctl_pkg::OFS_SYNC);
      if (rdata === 32'h0000_0000) break;
    end
    idle(2);
  endtask

  // Watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    error_cnt = error_cnt + 1;
    close_out();
  end

  initial begin
    nrst_i = 1'b0; psel_i = 1'b0; penable_i = 1'b0; pwrite_i = 1'b0; paddr_i = 8'h00;
    pwdata_i = 32'h0000_0000; data_write_i = 1'b0;
    addr_ref = 8'h40;
    addr_alt = 8'h20;
    error_cnt = 0; n_checks = 0; cyc = 0; last_tick = 0; tick_per = 0;
    n_wake = 0; n_pre = 0; n_flush = 0;
    repeat (5) @(posedge ref_clk_i);
    @(negedge ref_clk_i) nrst_i = 1'b1;
    // Reset values, three unmapped places included
    foreach (AD[i]) begin
      rd(8'(8 * i));
      chk(rdata, 32'h0000_0000);
    end
    rd(spi_ctl_pkg::OFS_IRQ); chk(rdata, 32'h0000_0000);
    // Disabled: baud and second control take writes
    wr(spi_ctl_pkg::OFS_BAUD, 32'h0000_0003); chk(32'(slverr), 32'h0);
    chk(32'(pready_o), 32'h1);
    rd(spi_ctl_pkg::OFS_BAUD); chk(rdata, 32'h0000_0003);
    wr(spi_ctl_pkg::OFS_SECOND, C2);
    rd(spi_ctl_pkg::OFS_SECOND); chk(rdata, C2);
    chk(32'(nine_bit_o), 32'h1);
    wr(spi_ctl_pkg::OFS_IRQ, 32'h00FF_0000);
    rd(spi_ctl_pkg::OFS_IRQ); chk(rdata, 32'h008F_008F);
    wr(spi_ctl_pkg::OFS_IRQ, 32'h0000_0005);
    rd(spi_ctl_pkg::OFS_IRQ); chk(rdata, 32'h008A_008A);
    chk(32'(irq_enable_o), 32'h0000_008A);
    // Slave with addressed frames, every address mode
    for (int m = 0; m < 4; m++) begin
      wr(spi_ctl_pkg::OFS_FIRST, 32'h0200_0008);
      wait_sync();
      wr(spi_ctl_pkg::OFS_SECOND, C2 | (32'(m) << 14));
      wr(spi_ctl_pkg::OFS_FIRST, 32'h0200_000A);
      rd(spi_ctl_pkg::OFS_FIRST); chk(rdata, 32'h0200_000A);
      rd(spi_ctl_pkg::OFS_SYNC); chk(rdata & 32'h2, 32'h2);
      if (m == 0) begin
        rd(spi_ctl_pkg::OFS_SECOND); chk(rdata, 32'h0000_2241);
      end
      wait_sync();
      chk(32'(enabled_o), 32'h1);
      chk(32'(master_o), 32'h0);
      for (int k = 0; k < 2; k++) begin
        u_peer.send_addr(AD[m][k]);
        idle(2);
        chk(32'(addr_match_o), EX[m][k]);
      end
      // A mask on bit 0 instead of bit 5 lets the address that missed above through
      if (m == 0) begin
        @(negedge ref_clk_i) addr_alt = 8'h01;
        u_peer.send_addr(8'h41);
        idle(2);
        chk(32'(addr_match_o), 32'h1);
        @(negedge ref_clk_i) addr_alt = 8'h20;
      end
    end
    // Falling select wakes; idle data write preloads
    w0 = n_wake; u_peer.set_sel(1'b0); idle(3); chk(32'(n_wake - w0), 32'h1);
    u_peer.set_sel(1'b1);
    w0 = n_pre;
    @(negedge ref_clk_i) data_write_i = 1'b1;
    @(negedge ref_clk_i) data_write_i = 1'b0;
    idle(3); chk(32'(n_pre - w0), 32'h1);
    // Enabled: baud is protected
    wr(spi_ctl_pkg::OFS_BAUD, 32'h0000_0055);
    rd(spi_ctl_pkg::OFS_BAUD); chk(rdata, 32'h0000_0003);
    // Overrun then receiver off
    u_peer.pulse_ovf(); idle(2); chk(32'(rx_overrun_flag_o), 32'h1);
    w0 = n_flush;
    wr(spi_ctl_pkg::OFS_SECOND, 32'h0000_0000); idle(3);
    chk(32'(n_flush - w0), 32'h1);
    chk({30'h0, rx_overrun_flag_o, receiver_on_o}, 32'h0);
    // Receiver back on while enabled
    wr(spi_ctl_pkg::OFS_SECOND, 32'h0002_0000);
    rd(spi_ctl_pkg::OFS_SYNC); chk(rdata, 32'h0000_0004);
    wait_sync();
    rd(spi_ctl_pkg::OFS_SECOND); chk(rdata, 32'h0002_E241);
    chk(32'(receiver_on_o), 32'h1);
    // Master role: address mode ignored, hardware select, tick spacing
    wr(spi_ctl_pkg::OFS_FIRST, 32'h0000_0008);
    wait_sync();
    wr(spi_ctl_pkg::OFS_FIRST, 32'h0000_000E);
    wait_sync();
    chk({30'h0, master_o, sel_oe_o}, 32'h3);
    u_peer.send_addr(8'h41); idle(2); chk(32'(addr_match_o), 32'h1);
    idle(12); chk(32'(tick_per), 32'h4);
    u_peer.set_xfer(1'b1); idle(2); chk(32'(sel_n_o), 32'h0);
    u_peer.set_xfer(1'b0);
    // Soft reset wins over enable in the same write
    wr(spi_ctl_pkg::OFS_FIRST, 32'h0000_0003);
    wr(spi_ctl_pkg::OFS_BAUD, 32'h0000_0077); chk(32'(slverr), 32'h1);
    wait_sync();
    rd(spi_ctl_pkg::OFS_BAUD); chk(rdata, 32'h0000_0000);
    rd(spi_ctl_pkg::OFS_FIRST); chk(rdata, 32'h0000_0000);
    chk(32'(enabled_o), 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
